// [logic/sbit_timer.sv]
// Sixteen-bit interval timer with compare, auto-capture and register port
//
// Summary of operation
// - A 16-bit up-counter works with a 16-bit compare and a 16-bit capture register under one control register.
// - While running the counter steps once per source tick, and on reaching the compare value raises the interrupt and clears.
// - After a match clear the counter keeps counting from zero, so interrupts repeat without software.
// - Run code 00 stops and clears the counter, 01 starts it, 10 and 11 are reserved.
// - Source select 00, 01, 10 picks fc/2^11, fc/2^7, fc/2^3, each halved again under divider doubling, 11 reserved.
// - Only timer mode is supported; other mode codes are reserved.
// - Compare writes are buffered and go live on the first source tick after the upper byte is written.
// - Writing only the lower compare byte leaves the live compare value alone unless an upper-byte write still awaits its tick.
// - With auto-capture on, each counting step except the clearing step at a match copies the new count into the capture register.
`timescale 1ns/1ps

`include "sbit_cfg.svh"

module sbit_timer #(
  parameter logic [15:0] CMP_RESET = `SBIT_CMP_RST,
  parameter int PRE_W = `SBIT_PRE_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`SBIT_ADDR_W-1:0] reg_addr,
  input wire logic [`SBIT_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SBIT_DATA_W-1:0] reg_rdata,
  input wire logic divider_doubling_select,
  output logic match_interrupt
);

  sbit_pkg::sbit_state_t s_r;
  sbit_pkg::sbit_state_t s_nxt;

  logic tick;
  logic tap_en;
  logic [3:0] tap_exp;
  logic [3:0] tap_base;
  logic [15:0] cnt_inc;
  logic hi_wr;
  logic count_en;
  logic match_hit;
  // Decoded control fields
  sbit_pkg::sbit_run_t run_control;
  sbit_pkg::sbit_clk_sel_t source_clock_select;
  sbit_pkg::sbit_mode_t operating_mode_select;
  logic auto_capture_enable;

  // Field decode of the live control register
  always_comb begin
    run_control = sbit_pkg::sbit_run_t'(s_r.ctrl[`SBIT_CTRL_RUN_HI:`SBIT_CTRL_RUN_LO]);
    source_clock_select =
      sbit_pkg::sbit_clk_sel_t'(s_r.ctrl[`SBIT_CTRL_CK_HI:`SBIT_CTRL_CK_LO]);
    operating_mode_select =
      sbit_pkg::sbit_mode_t'(s_r.ctrl[`SBIT_CTRL_MODE_HI:`SBIT_CTRL_MODE_LO]);
    auto_capture_enable = s_r.ctrl[`SBIT_CTRL_ACAP];
  end

  // Tap choice; reserved code gives no tick at all
  always_comb begin
    tap_en = 1'b1;
    case (source_clock_select)
      sbit_pkg::SBIT_CK_SLOW: begin
        tap_base = `SBIT_TAP_SLOW;
      end
      sbit_pkg::SBIT_CK_MID: begin
        tap_base = `SBIT_TAP_MID;
      end
      sbit_pkg::SBIT_CK_FAST: begin
        tap_base = `SBIT_TAP_FAST;
      end
      default: begin
        tap_base = `SBIT_TAP_SLOW;
        tap_en = 1'b0;
      end
    endcase
    // Doubling adds one to the exponent, halving every tap
    tap_exp = tap_base + {3'b000, divider_doubling_select};
  end

  // Prescaler runs from reset and a start never clears it, so the
  // first period after a start may be short
  sbit_prescaler #(
    .PRE_W(PRE_W)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .tap_exp(tap_exp),
    .tap_en(tap_en),
    .tick(tick)
  );

  // Reserved modes never step the count
  always_comb begin
    cnt_inc = s_r.cnt + 16'h0001;
    count_en = tick && (operating_mode_select == sbit_pkg::SBIT_MODE_TIMER);
    match_hit = (cnt_inc == s_r.cmp_act);
  end

  always_comb begin
    s_nxt = s_r;
    // Interrupt and read data last one cycle unless set again
    s_nxt.irq = 1'b0;
    s_nxt.rdata = '0;
    hi_wr = reg_wr && (reg_addr == `SBIT_ADDR_CMP_HI);

    // Buffered compare goes live on a tick; a high write in the tick cycle waits a tick
    if (tick && s_r.cmp_pend && !hi_wr) begin
      s_nxt.cmp_act = s_r.cmp_buf;
      s_nxt.cmp_pend = 1'b0;
    end

    // Counter
    case (run_control)
      sbit_pkg::SBIT_RUN_STOP: begin
        // Cleared every cycle, so a restart always begins from zero
        s_nxt.cnt = `SBIT_CNT_RST;
      end
      sbit_pkg::SBIT_RUN_START: begin
        if (count_en) begin
          if (match_hit) begin
            s_nxt.cnt = `SBIT_CNT_RST;
            s_nxt.irq = 1'b1;
          end else begin
            s_nxt.cnt = cnt_inc;
            // The zero after a match is never captured
            if (auto_capture_enable) begin
              s_nxt.cap = cnt_inc;
            end
          end
        end
      end
      default: begin
        // Reserved run codes freeze the count without clearing
        s_nxt.cnt = s_r.cnt;
      end
    endcase

    // Register writes
    // Control fields act from the next cycle; this cycle's step uses the old ones
    if (reg_wr) begin
      case (reg_addr)
        `SBIT_ADDR_CTRL: begin
          // Bit 7 is held at zero whatever is written
          s_nxt.ctrl = {1'b0, reg_wdata[`SBIT_CTRL_RSVD-1:0]};
        end
        `SBIT_ADDR_CMP_LO: begin
          // Low byte alone only fills the buffer
          s_nxt.cmp_buf[7:0] = reg_wdata;
        end
        `SBIT_ADDR_CMP_HI: begin
          s_nxt.cmp_buf[15:8] = reg_wdata;
          s_nxt.cmp_pend = 1'b1;
        end
        default: begin
          s_nxt.cmp_pend = s_nxt.cmp_pend;
        end
      endcase
    end

    // Register reads; data stands one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `SBIT_ADDR_CTRL: begin
          s_nxt.rdata = s_r.ctrl;
        end
        `SBIT_ADDR_CMP_LO: begin
          s_nxt.rdata = s_r.cmp_buf[7:0];
        end
        `SBIT_ADDR_CMP_HI: begin
          s_nxt.rdata = s_r.cmp_buf[15:8];
        end
        `SBIT_ADDR_CAP_LO: begin
          // Upper byte frozen here so a low-then-high read pair is coherent
          s_nxt.rdata = s_r.cap[7:0];
          s_nxt.cap_hold = s_r.cap[15:8];
        end
        `SBIT_ADDR_CAP_HI: begin
          // Without a low read first this gives the last latched byte
          s_nxt.rdata = s_r.cap_hold;
        end
        default: begin
          // Unmapped addresses read as zero
          s_nxt.rdata = '0;
        end
      endcase
    end
  end

  // Compare comes up at its parameter value, all else at fixed values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{
        ctrl: `SBIT_CTRL_RST,
        cmp_buf: CMP_RESET,
        cmp_act: CMP_RESET,
        cmp_pend: 1'b0,
        cnt: `SBIT_CNT_RST,
        cap: `SBIT_CAP_RST,
        cap_hold: 8'h00,
        irq: 1'b0,
        rdata: 8'h00
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // Both outputs come straight from state flops
  always_comb begin
    reg_rdata = s_r.rdata;
    match_interrupt = s_r.irq;
  end

endmodule // sbit_timer

// [logic/sbit_cfg.svh]
// Register offsets, field positions, reset values and prescaler taps of the interval timer
`ifndef SBIT_CFG_SVH
`define SBIT_CFG_SVH

`define SBIT_ADDR_W 4
`define SBIT_DATA_W 8

`define SBIT_ADDR_CTRL 4'h0
`define SBIT_ADDR_CMP_LO 4'h1
`define SBIT_ADDR_CMP_HI 4'h2
`define SBIT_ADDR_CAP_LO 4'h3
`define SBIT_ADDR_CAP_HI 4'h4

`define SBIT_CTRL_RSVD 7
`define SBIT_CTRL_ACAP 6
`define SBIT_CTRL_RUN_HI 5
`define SBIT_CTRL_RUN_LO 4
`define SBIT_CTRL_CK_HI 3
`define SBIT_CTRL_CK_LO 2
`define SBIT_CTRL_MODE_HI 1
`define SBIT_CTRL_MODE_LO 0

`define SBIT_CTRL_RST 8'h00
`define SBIT_CMP_RST 16'hffff
`define SBIT_CAP_RST 16'h0000
`define SBIT_CNT_RST 16'h0000

`define SBIT_TAP_SLOW 4'hb
`define SBIT_TAP_MID 4'h7
`define SBIT_TAP_FAST 4'h3

`define SBIT_PRE_W 13

`endif

// [logic/sbit_pkg.sv]
// Types shared by the interval timer modules
package sbit_pkg;

  typedef enum logic [1:0] {
    SBIT_RUN_STOP = 2'b00,
    SBIT_RUN_START = 2'b01,
    SBIT_RUN_RSVD2 = 2'b10,
    SBIT_RUN_RSVD3 = 2'b11
  } sbit_run_t;

  typedef enum logic [1:0] {
    SBIT_CK_SLOW = 2'b00,
    SBIT_CK_MID = 2'b01,
    SBIT_CK_FAST = 2'b10,
    SBIT_CK_RSVD = 2'b11
  } sbit_clk_sel_t;

  typedef enum logic [1:0] {
    SBIT_MODE_TIMER = 2'b00,
    SBIT_MODE_RSVD1 = 2'b01,
    SBIT_MODE_RSVD2 = 2'b10,
    SBIT_MODE_RSVD3 = 2'b11
  } sbit_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cmp_buf;
    logic [15:0] cmp_act;
    logic cmp_pend;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0] cap_hold;
    logic irq;
    logic [7:0] rdata;
  } sbit_state_t;

endpackage

// [logic/sbit_prescaler.sv]
// Free-running prescaler giving a one-cycle tick every 2^tap_exp system clocks
`timescale 1ns/1ps

module sbit_prescaler #(
  parameter int PRE_W = 13
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] tap_exp,
  input wire logic tap_en,
  output logic tick
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } sbit_pre_state_t;

  sbit_pre_state_t s_r;
  sbit_pre_state_t s_nxt;
  logic [PRE_W-1:0] mask;

  // Never cleared by software, so the first period after a start may be short
  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + PRE_W'(1);
    mask = (PRE_W'(1) << tap_exp) - PRE_W'(1);
    tick = tap_en && ((s_r.cnt & mask) == mask);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // sbit_prescaler

// [test/sbit_timer_props.sv]
// Port-level assertions for the interval timer
`timescale 1ns/1ps
module sbit_timer_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic divider_doubling_select,
  input wire logic match_interrupt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wr_rd(a);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
  endsequence
  sequence stop_wr;
    reg_wr && reg_addr == 4'h0 && reg_wdata[5:4] == 2'b00;
  endsequence
  chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_unmapped_rd: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_back: assert property (wr_rd(4'h0) |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
    else $error("control readback wrong");
  chk_cmp_lo_back: assert property (wr_rd(4'h1) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("compare low readback wrong");
  chk_cmp_hi_back: assert property (wr_rd(4'h2) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("compare high readback wrong");
  chk_irq_gap: assert property (match_interrupt |=> !match_interrupt [*7])
    else $error("interrupts too close");
  chk_stop_quiet: assert property (stop_wr |-> ##2 !match_interrupt [*6])
    else $error("interrupt while stopped");
  chk_rst_quiet: assert property ($fell(rst) |-> !match_interrupt ##1 !match_interrupt)
    else $error("interrupt after reset");
endmodule // sbit_timer_props

bind sbit_timer sbit_timer_props chk_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .divider_doubling_select, .match_interrupt);

// [test/sbit_timer_tb_top.sv]
// Self-checking bench for the interval timer
`timescale 1ns/1ps
module sbit_timer_tb_top;
  typedef struct {
    logic [1:0] src;
    logic dd;
    logic [15:0] cmp;
    int tick;
  } sbit_row_t;
  // Source code, doubling, compare, cycles per tick
  sbit_row_t rows [4] = '{'{2'b00, 1'b0, 16'h0002, 2048}, '{2'b01, 1'b1, 16'h0003, 256},
    '{2'b10, 1'b0, 16'h0002, 8}, '{2'b10, 1'b1, 16'h0005, 16}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic dd = 1'b0;
  logic [7:0] reg_rdata;
  logic match_interrupt;
  int errors = 0;
  int n_compared = 0;
  always #12.5 sys_clk = ~sys_clk;
  sbit_timer dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .divider_doubling_select(dd), .match_interrupt);
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    // Back-to-back writes need a fresh edge to raise the strobe again
    if (reg_wr === 1'b1) @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [3:0] a, logic [7:0] exp, string what);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    n_compared++;
    if (reg_rdata !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, reg_rdata);
    end
    @(posedge sys_clk);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (match_interrupt !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      errors++;
      $display("BAD match_interrupt exp 1 got %b", match_interrupt);
      report_and_stop();
    end
    @(posedge sys_clk);
  endtask
  task automatic period_chk(int exp, string what);
    int n;
    wait_irq(n);
    wait_irq(n);
    n_compared++;
    if (n != exp) begin
      errors++;
      $display("BAD %s exp %0d got %0d", what, exp, n);
    end
  endtask
  task automatic quiet_chk(int cycles, string what);
    int n;
    n = 0;
    repeat (cycles) begin
      @(negedge sys_clk);
      if (match_interrupt !== 1'b0) n++;
    end
    n_compared++;
    if (n != 0) begin
      errors++;
      $display("BAD %s exp 0 got %0d", what, n);
    end
    @(posedge sys_clk);
  endtask
  initial begin
    int n;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(4'h0, 8'h00, "ctrl");
    rd_chk(4'h1, 8'hff, "cmp_lo");
    rd_chk(4'h2, 8'hff, "cmp_hi");
    rd_chk(4'h3, 8'h00, "cap_lo");
    rd_chk(4'h9, 8'h00, "unmapped");
    foreach (rows[i]) begin
      wr(4'h0, {4'h0, rows[i].src, 2'b00});
      dd <= rows[i].dd;
      wr(4'h1, rows[i].cmp[7:0]);
      wr(4'h2, rows[i].cmp[15:8]);
      // Compare loads only on a tick, so let one pass before starting
      repeat (rows[i].tick + 2) @(posedge sys_clk);
      wr(4'h0, {4'h1, rows[i].src, 2'b00});
      period_chk(rows[i].cmp * rows[i].tick, "period");
      // Stop first so the next row changes its source only while stopped
      wr(4'h0, {4'h0, rows[i].src, 2'b00});
    end
    wr(4'h0, 8'h18);
    dd <= 1'b0;
    repeat (20) @(posedge sys_clk);
    wr(4'h0, 8'h58);
    rd_chk(4'h0, 8'h58, "ctrl back");
    wait_irq(n);
    // Two ticks of eight cycles after the match
    repeat (20) @(posedge sys_clk);
    rd_chk(4'h3, 8'h02, "capture");
    rd_chk(4'h4, 8'h00, "capture high");
    wr(4'h1, 8'h02);
    rd_chk(4'h1, 8'h02, "cmp_lo back");
    period_chk(40, "low byte only");
    wr(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00, "cmp_hi back");
    period_chk(16, "new compare");
    // Reserved codes must stay quiet although compare 2 would fire in 16 cycles
    wr(4'h0, 8'h08);
    wr(4'h0, 8'h09);
    wr(4'h0, 8'h19);
    quiet_chk(40, "reserved mode");
    wr(4'h0, 8'h09);
    wr(4'h0, 8'h0c);
    wr(4'h0, 8'h1c);
    quiet_chk(40, "reserved source");
    wr(4'h0, 8'h0c);
    wr(4'h0, 8'h28);
    quiet_chk(40, "reserved run");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(4'h0, 8'h00, "ctrl after reset");
    rd_chk(4'h1, 8'hff, "cmp after reset");
    report_and_stop();
  end
endmodule // sbit_timer_tb_top
